// File: hdl/tpf_pin_format.sv
// Per-pin drive format, compare masking and pattern memory of a test station
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "tpf_defines.svh"
module tpf_pin_format (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic [7:0]           i_addr,
	input  wire logic [31:0]          i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [31:0]          o_rdata,
	input  wire logic [`TPF_PINS-1:0] i_pin_level,
	output logic      [`TPF_PINS-1:0] o_pin_drive,
	output logic      [`TPF_PINS-1:0] o_fast_switch,
	output logic      [`TPF_PINS-1:0] o_driver_relay,
	output logic                      o_cycle_start,
	output logic                      o_irq
);
	tpf_pkg::tpf_state_type q;
	tpf_pkg::tpf_state_type d;
	tpf_pkg::tpf_word_type  mem [0:`TPF_DEPTH-1];
	tpf_pkg::tpf_word_type  word;
	tpf_pkg::tpf_pins_type  level;
	tpf_pkg::tpf_pins_type  drv_act;
	tpf_pkg::tpf_pins_type  cmp_act;
	tpf_pkg::tpf_pins_type  data;
	tpf_pkg::tpf_pins_type  dd;
	tpf_pkg::tpf_pins_type  strobe_on;
	tpf_pkg::tpf_pins_type  fail;
	logic [2:0]             ev;
	logic                   clr_res;
	logic                   clr_st;
	logic                   pat_store;
	logic                   early_win;
	logic                   late_win;
	logic                   pulse_win;

	// Writes one 32-bit half of a pin vector; the upper half holds pins 32 and up
	function automatic tpf_pkg::tpf_pins_type set_half(
		input tpf_pkg::tpf_pins_type old,
		input logic                  hi,
		input logic [31:0]           w
	);
		tpf_pkg::tpf_pins_type r;
		r = old;
		if (hi) begin
			r[`TPF_PINS-1:32] = w[`TPF_PINS-33:0];
		end else begin
			r[31:0] = w;
		end
		return r;
	endfunction

	function automatic logic [31:0] get_half(
		input tpf_pkg::tpf_pins_type v,
		input logic                  hi
	);
		logic [31:0] r;
		r = '0;
		if (hi) begin
			r[`TPF_PINS-33:0] = v[`TPF_PINS-1:32];
		end else begin
			r = v[31:0];
		end
		return r;
	endfunction

	tpf_pin_sync #(
		.WIDTH (`TPF_PINS)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (i_pin_level),
		.o_level (level)
	);

	tpf_window_gen u_early_strobe_gen (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_start  (q.cycle_start),
		.i_delay  (q.early_t[7:0]),
		.i_width  (q.early_t[15:8]),
		.o_window (early_win)
	);

	tpf_window_gen u_late_strobe_gen (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_start  (q.cycle_start),
		.i_delay  (q.late_t[7:0]),
		.i_width  (q.late_t[15:8]),
		.o_window (late_win)
	);

	// Return-low pulse shares the window logic of the strobes
	tpf_window_gen u_drive_pulse_gen (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_start  (q.cycle_start),
		.i_delay  (q.pulse_t[7:0]),
		.i_width  (q.pulse_t[15:8]),
		.o_window (pulse_win)
	);

	assign pat_store = i_wr && (i_addr == `TPF_OFF_PAT_HI);
	assign word      = mem[q.run_addr];

	always_comb begin
		d = q;
		ev = 3'h0;
		clr_res = 1'b0;
		clr_st = i_rd && (i_addr == `TPF_OFF_STATUS);
		drv_act = word[`TPF_W_DRV_SEL] ? q.drv2 : q.drv1;
		cmp_act = word[`TPF_W_CMP_SEL] ? q.cmp2 : q.cmp1;
		d.cycle_start = 1'b0;
		d.rdata = 32'h0000_0000;

		if (i_wr) begin
			if (i_addr == `TPF_OFF_CTRL) begin
				d.ctrl = i_wdata[3:0];
			end else if (i_addr == `TPF_OFF_IRQ_MASK) begin
				d.irq_mask = i_wdata[2:0];
			end else if (i_addr == `TPF_OFF_LOAD_PTR) begin
				d.load_ptr = i_wdata[5:0];
			end else if (i_addr == `TPF_OFF_PAT_LO) begin
				d.pat_lo = i_wdata;
			end else if (pat_store) begin
				d.load_ptr = q.load_ptr + 6'h01;
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_DRV1) begin
				d.drv1 = set_half(q.drv1, i_addr[2], i_wdata);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_DRV2) begin
				d.drv2 = set_half(q.drv2, i_addr[2], i_wdata);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_CMP1) begin
				d.cmp1 = set_half(q.cmp1, i_addr[2], i_wdata);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_CMP2) begin
				d.cmp2 = set_half(q.cmp2, i_addr[2], i_wdata);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_STB_SEL) begin
				d.stb_sel = set_half(q.stb_sel, i_addr[2], i_wdata);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_INVERT) begin
				d.invert = set_half(q.invert, i_addr[2], i_wdata);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_RET_LOW) begin
				d.ret_low = set_half(q.ret_low, i_addr[2], i_wdata);
			end else if (i_addr == `TPF_OFF_RESULT) begin
				clr_res = 1'b1;
			end else if (i_addr == `TPF_OFF_EARLY) begin
				d.early_t = i_wdata[15:0];
			end else if (i_addr == `TPF_OFF_LATE) begin
				d.late_t = i_wdata[15:0];
			end else if (i_addr == `TPF_OFF_PULSE) begin
				d.pulse_t = i_wdata[15:0];
			end else if (i_addr == `TPF_OFF_PERIOD) begin
				d.period = i_wdata[7:0];
			end
		end

		if (i_rd) begin
			if (i_addr == `TPF_OFF_CTRL) begin
				d.rdata[3:0] = q.ctrl;
			end else if (i_addr == `TPF_OFF_STATUS) begin
				d.rdata[2:0] = q.status;
			end else if (i_addr == `TPF_OFF_IRQ_MASK) begin
				d.rdata[2:0] = q.irq_mask;
			end else if (i_addr == `TPF_OFF_LOAD_PTR) begin
				d.rdata[5:0] = q.load_ptr;
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_DRV1) begin
				d.rdata = get_half(q.drv1, i_addr[2]);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_DRV2) begin
				d.rdata = get_half(q.drv2, i_addr[2]);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_CMP1) begin
				d.rdata = get_half(q.cmp1, i_addr[2]);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_CMP2) begin
				d.rdata = get_half(q.cmp2, i_addr[2]);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_STB_SEL) begin
				d.rdata = get_half(q.stb_sel, i_addr[2]);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_INVERT) begin
				d.rdata = get_half(q.invert, i_addr[2]);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_RET_LOW) begin
				d.rdata = get_half(q.ret_low, i_addr[2]);
			end else if ({i_addr[7:3], 3'b000} == `TPF_OFF_RESULT) begin
				d.rdata = get_half(q.result, i_addr[2]);
			end else if (i_addr == `TPF_OFF_EARLY) begin
				d.rdata[15:0] = q.early_t;
			end else if (i_addr == `TPF_OFF_LATE) begin
				d.rdata[15:0] = q.late_t;
			end else if (i_addr == `TPF_OFF_PULSE) begin
				d.rdata[15:0] = q.pulse_t;
			end else if (i_addr == `TPF_OFF_PERIOD) begin
				d.rdata[7:0] = q.period;
			end
		end

		case (q.run_st)
			tpf_pkg::TPF_IDLE: begin
				// An empty memory gives nothing to play
				if (q.ctrl[`TPF_CTRL_RUN] && (q.load_ptr != 6'h00)) begin
					d.run_st = tpf_pkg::TPF_RUN;
					d.tick = q.period - 8'h01;
					d.run_addr = 6'h00;
				end
			end
			tpf_pkg::TPF_RUN: begin
				if (!q.ctrl[`TPF_CTRL_RUN]) begin
					d.run_st = tpf_pkg::TPF_IDLE;
				end else if (q.tick == q.period - 8'h01) begin
					d.tick = 8'h00;
					d.cycle_start = 1'b1;
					ev[`TPF_ST_CYCLE] = 1'b1;
					d.cyc_word = word;
					d.cyc_drv_sel = word[`TPF_W_DRV_SEL];
					d.cyc_cmp_sel = word[`TPF_W_CMP_SEL];
					// Masks resolved once so mid-cycle writes cannot glitch compare
					d.cyc_care = cmp_act & ~({`TPF_PINS{q.ctrl[`TPF_CTRL_AUTO]}} & drv_act);
					d.fast_sw = drv_act;
					d.relay = q.drv1 | q.drv2;
					d.cyc_stb = q.stb_sel;
					d.cyc_inv = q.invert;
					d.cyc_retlow = q.ret_low;
					d.cyc_dual = q.ctrl[`TPF_CTRL_DUAL];
					d.cyc_rhigh = q.ctrl[`TPF_CTRL_RHIGH];
					if (({1'b0, q.run_addr} + 7'h01) >= {1'b0, q.load_ptr}) begin
						d.run_addr = 6'h00;
						ev[`TPF_ST_WRAP] = 1'b1;
					end else begin
						d.run_addr = q.run_addr + 6'h01;
					end
				end else begin
					d.tick = q.tick + 8'h01;
				end
			end
			default: begin
				d.run_st = tpf_pkg::TPF_IDLE;
			end
		endcase

		data = q.cyc_word[`TPF_PINS-1:0];
		dd = data ^ q.cyc_inv;
		d.pin_out = (q.cyc_retlow & ((dd & {`TPF_PINS{pulse_win}})
			^ (q.cyc_inv & {`TPF_PINS{q.cyc_rhigh}})))
			| (~q.cyc_retlow & dd);

		strobe_on = (q.cyc_stb & {`TPF_PINS{late_win}})
			| (~q.cyc_stb & {`TPF_PINS{early_win | (q.cyc_dual & late_win)}});
		fail = q.cyc_care & strobe_on & (level ^ data)
			& {`TPF_PINS{q.run_st == tpf_pkg::TPF_RUN}};
		// A fail in the clearing cycle survives the clear
		d.result = (clr_res ? '0 : q.result) | fail;
		ev[`TPF_ST_FAIL] = |fail;

		d.status = (clr_st ? 3'h0 : q.status) | ev;
		d.irq = |(d.status & q.irq_mask);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
			q.period <= `TPF_PERIOD_RST;
			q.early_t <= `TPF_EARLY_RST;
			q.late_t <= `TPF_LATE_RST;
			q.pulse_t <= `TPF_PULSE_RST;
		end else begin
			q <= d;
		end
	end

	// No reset: contents are only meaningful once loaded
	always_ff @(posedge i_clk) begin
		if (pat_store) begin
			mem[q.load_ptr] <= {i_wdata[`TPF_WORD_W-33:0], q.pat_lo};
		end
	end

	assign o_rdata        = q.rdata;
	assign o_pin_drive    = q.pin_out;
	assign o_fast_switch  = q.fast_sw;
	assign o_driver_relay = q.relay;
	assign o_cycle_start  = q.cycle_start;
	assign o_irq          = q.irq;

	a_drive_sel_start: assert property (@(posedge i_clk) disable iff (i_rst)
		!q.cycle_start |-> $stable(q.cyc_drv_sel))
		else $error("drive set changed outside cycle start");
	a_first_drive_set: assert property (@(posedge i_clk)
		$fell(i_rst) |-> !q.cyc_drv_sel && (q.fast_sw == '0))
		else $error("second drive set active before selection");
	a_first_cmp_set: assert property (@(posedge i_clk)
		$fell(i_rst) |-> !q.cyc_cmp_sel && (q.cyc_care == '0))
		else $error("second compare set active before selection");
	a_care_from_set: assert property (@(posedge i_clk) disable iff (i_rst)
		q.cycle_start && !$past(q.ctrl[`TPF_CTRL_AUTO]) |->
		q.cyc_care == (q.cyc_cmp_sel ? $past(q.cmp2) : $past(q.cmp1)))
		else $error("care mask not taken from selected compare set");
	a_fail_only_care: assert property (@(posedge i_clk) disable iff (i_rst)
		(q.result & ~$past(q.result) & ~$past(q.cyc_care)) == '0)
		else $error("fail latched on a don't care pin");
	a_auto_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
		q.cycle_start && $past(q.ctrl[`TPF_CTRL_AUTO]) |-> (q.cyc_care & q.fast_sw) == '0)
		else $error("driven pin compared while auto ignore on");
	a_late_route: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(late_win) |-> (q.result & ~$past(q.result) & $past(q.cyc_stb)) == '0)
		else $error("late-strobe pin failed outside late window");
	a_early_route: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(early_win) && !($past(q.cyc_dual) && $past(late_win)) |->
		(q.result & ~$past(q.result) & ~$past(q.cyc_stb)) == '0)
		else $error("early-strobe pin failed outside its windows");
	a_load_advance: assert property (@(posedge i_clk) disable iff (i_rst)
		pat_store |=> q.load_ptr == $past(q.load_ptr) + 6'h01)
		else $error("load pointer did not advance");
	a_nrz_drive: assert property (@(posedge i_clk) disable iff (i_rst)
		((q.pin_out ^ $past(q.cyc_word[`TPF_PINS-1:0] ^ q.cyc_inv)) & ~$past(q.cyc_retlow)) == '0)
		else $error("non-return drive level wrong");
	a_ret_wave: assert property (@(posedge i_clk) disable iff (i_rst)
		((q.pin_out ^ $past(((q.cyc_word[`TPF_PINS-1:0] ^ q.cyc_inv) & {`TPF_PINS{pulse_win}})
		^ (q.cyc_inv & {`TPF_PINS{q.cyc_rhigh}}))) & $past(q.cyc_retlow)) == '0)
		else $error("return format waveform wrong");
	a_relay_or: assert property (@(posedge i_clk) disable iff (i_rst)
		q.cycle_start |-> q.relay == ($past(q.drv1) | $past(q.drv2)))
		else $error("relay not the OR of both drive sets");
	a_fast_switch: assert property (@(posedge i_clk) disable iff (i_rst)
		q.cycle_start |-> q.fast_sw == (q.cyc_drv_sel ? $past(q.drv2) : $past(q.drv1)))
		else $error("fast switch not from active drive set");
	a_switch_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!q.cycle_start |-> $stable(q.fast_sw))
		else $error("fast switch changed outside cycle start");
	a_relay_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!q.cycle_start |-> $stable(q.relay))
		else $error("relay changed outside cycle start");
	a_cmp_sel_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!q.cycle_start |-> $stable(q.cyc_cmp_sel) && $stable(q.cyc_care))
		else $error("compare set changed outside cycle start");
	a_fail_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
		(fail != '0) |=> (q.result & $past(fail)) == $past(fail))
		else $error("strobed fail lost from result");

	c_cycle: cover property (@(posedge i_clk) disable iff (i_rst) q.cycle_start);
	c_fail: cover property (@(posedge i_clk) disable iff (i_rst) q.status[`TPF_ST_FAIL]);
	c_dual_late: cover property (@(posedge i_clk) disable iff (i_rst)
		q.cyc_dual && late_win && (fail != '0));
	c_wrap: cover property (@(posedge i_clk) disable iff (i_rst) q.status[`TPF_ST_WRAP]);
	c_auto_ignore: cover property (@(posedge i_clk) disable iff (i_rst)
		q.cycle_start && q.ctrl[`TPF_CTRL_AUTO]);
endmodule // tpf_pin_format
`default_nettype wire

// File: common/tpf_defines.svh
// Constants of the tester pin format and compare block
`ifndef TPF_DEFINES_SVH
`define TPF_DEFINES_SVH
`define TPF_PINS         60
`define TPF_DEPTH        64
`define TPF_WORD_W       62
`define TPF_W_DRV_SEL    60
`define TPF_W_CMP_SEL    61
`define TPF_OFF_CTRL     8'h00
`define TPF_OFF_STATUS   8'h04
`define TPF_OFF_IRQ_MASK 8'h08
`define TPF_OFF_LOAD_PTR 8'h0C
`define TPF_OFF_PAT_LO   8'h10
`define TPF_OFF_PAT_HI   8'h14
`define TPF_OFF_DRV1     8'h18
`define TPF_OFF_DRV2     8'h20
`define TPF_OFF_CMP1     8'h28
`define TPF_OFF_CMP2     8'h30
`define TPF_OFF_STB_SEL  8'h38
`define TPF_OFF_INVERT   8'h40
`define TPF_OFF_RET_LOW  8'h48
`define TPF_OFF_RESULT   8'h50
`define TPF_OFF_EARLY    8'h58
`define TPF_OFF_LATE     8'h5C
`define TPF_OFF_PULSE    8'h60
`define TPF_OFF_PERIOD   8'h64
`define TPF_CTRL_RUN     0
`define TPF_CTRL_AUTO    1
`define TPF_CTRL_DUAL    2
`define TPF_CTRL_RHIGH   3
`define TPF_ST_FAIL      0
`define TPF_ST_WRAP      1
`define TPF_ST_CYCLE     2
`define TPF_PERIOD_RST   8'h20
`define TPF_EARLY_RST    16'h0408
`define TPF_LATE_RST     16'h0410
`define TPF_PULSE_RST    16'h0804
`endif

// File: common/tpf_pkg.sv
// Types of the tester pin format and compare block
`include "tpf_defines.svh"
package tpf_pkg;
	typedef logic [`TPF_PINS-1:0]   tpf_pins_type;
	typedef logic [`TPF_WORD_W-1:0] tpf_word_type;
	typedef enum logic {TPF_IDLE, TPF_RUN} tpf_run_type;
	typedef struct packed {
		tpf_run_type  run_st;
		logic [3:0]   ctrl;
		logic [2:0]   status;
		logic [2:0]   irq_mask;
		logic [5:0]   load_ptr;
		logic [31:0]  pat_lo;
		tpf_pins_type drv1;
		tpf_pins_type drv2;
		tpf_pins_type cmp1;
		tpf_pins_type cmp2;
		tpf_pins_type stb_sel;
		tpf_pins_type invert;
		tpf_pins_type ret_low;
		tpf_pins_type result;
		logic [15:0]  early_t;
		logic [15:0]  late_t;
		logic [15:0]  pulse_t;
		logic [7:0]   period;
		logic [7:0]   tick;
		logic [5:0]   run_addr;
		logic         cycle_start;
		tpf_word_type cyc_word;
		logic         cyc_drv_sel;
		logic         cyc_cmp_sel;
		tpf_pins_type cyc_care;
		tpf_pins_type cyc_stb;
		tpf_pins_type cyc_inv;
		tpf_pins_type cyc_retlow;
		logic         cyc_dual;
		logic         cyc_rhigh;
		tpf_pins_type pin_out;
		tpf_pins_type fast_sw;
		tpf_pins_type relay;
		logic         irq;
		logic [31:0]  rdata;
	} tpf_state_type;
	typedef struct packed {
		logic       active;
		logic [8:0] cnt;
		logic       window;
	} tpf_win_type;
endpackage

// File: hdl/tpf_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/10ps
`default_nettype none
module tpf_pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] filt;
	} tpf_sync_type;

	tpf_sync_type q;
	tpf_sync_type d;
	logic [WIDTH-1:0] agree;

	always_comb begin
		d = q;
		agree = ~(q.s2 ^ q.s3);
		d.s1 = i_async;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// Only a level held over two samples is taken
		d.filt = (agree & q.s3) | (~agree & q.filt);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_level = q.filt;
endmodule // tpf_pin_sync
`default_nettype wire

// File: hdl/tpf_window_gen.sv
// Timing window generator: opens after a delay, stays open for a width
`timescale 1ns/10ps
`default_nettype none
module tpf_window_gen (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_start,
	input  wire logic [7:0] i_delay,
	input  wire logic [7:0] i_width,
	output logic            o_window
);
	tpf_pkg::tpf_win_type q;
	tpf_pkg::tpf_win_type d;
	logic [8:0] stop;
	logic [8:0] len_q;

	always_comb begin
		d = q;
		stop = {1'b0, i_delay} + {1'b0, i_width};
		if (i_start) begin
			d.active = 1'b1;
			d.cnt = 9'h000;
		end else if (q.cnt != 9'h1FF) begin
			d.cnt = q.cnt + 9'h001;
		end
		d.window = d.active && (d.cnt >= {1'b0, i_delay}) && (d.cnt < stop);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_window = q.window;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			len_q <= 9'h000;
		end else begin
			len_q <= q.window ? len_q + 9'h001 : 9'h000;
		end
	end

	a_window_width: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(q.window) && !$past(i_start) |-> len_q == {1'b0, $past(i_width)})
		else $error("strobe window width differs from programmed width");
	a_window_delay: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(q.window) |-> q.cnt == {1'b0, i_delay})
		else $error("strobe window opened at wrong delay");
endmodule // tpf_window_gen
`default_nettype wire

// File: common/README_unused.sv
// Intentionally empty
`default_nettype none
`default_nettype wire

// File: bench/tpf_dut_model.sv
// Behavioural device under test as seen through the pin electronics
`timescale 1ns/10ps
`default_nettype none
module tpf_dut_model (
	input  wire logic [59:0] i_drive,
	input  wire logic [59:0] i_switch,
	input  wire logic [59:0] i_resp,
	input  wire logic [59:0] i_fault,
	output logic      [59:0] o_level
);
	// Driven pins show the driver, the rest the device answer; fault bits model a bad part
	assign o_level = ((i_switch & i_drive) | (~i_switch & i_resp)) ^ i_fault;
endmodule // tpf_dut_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench of the pin format and compare block
`timescale 1ns/10ps
`default_nettype none
`include "tpf_defines.svh"
module testbench;
	logic                  i_clk;
	logic                  i_rst;
	logic [7:0]            i_addr;
	logic [31:0]           i_wdata;
	logic                  i_wr;
	logic                  i_rd;
	logic [31:0]           o_rdata;
	logic                  o_cycle_start;
	logic                  o_irq;
	tpf_pkg::tpf_pins_type pin_level;
	tpf_pkg::tpf_pins_type o_pin_drive;
	tpf_pkg::tpf_pins_type o_fast_switch;
	tpf_pkg::tpf_pins_type o_driver_relay;
	tpf_pkg::tpf_pins_type resp;
	tpf_pkg::tpf_pins_type fault;
	int                    failures;
	int                    tests_run;

	tpf_pin_format u_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_level(pin_level),
		.o_pin_drive(o_pin_drive), .o_fast_switch(o_fast_switch),
		.o_driver_relay(o_driver_relay), .o_cycle_start(o_cycle_start), .o_irq(o_irq)
	);
	tpf_dut_model u_model (
		.i_drive(o_pin_drive), .i_switch(o_fast_switch), .i_resp(resp),
		.i_fault(fault), .o_level(pin_level)
	);

	initial i_clk = 1'b0;
	always #10 i_clk = ~i_clk;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
	endtask
	task automatic wr60(input logic [7:0] a, input tpf_pkg::tpf_pins_type v);
		wr(a, v[31:0]);
		wr(a + 8'h04, {4'h0, v[59:32]});
	endtask
	// Bounded wait so a dead sequencer is reported, not hung on
	task automatic wait_start();
		int n;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (o_cycle_start !== 1'b1 && n < 300);
		check(n < 300, 1'b1);
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic tpf_pkg::tpf_pins_type rnd60();
		logic [63:0] t;
		t = {$urandom(), $urandom()};
		return t[59:0];
	endfunction
	// Driven pins see inversion against the raw expected bit
	function automatic tpf_pkg::tpf_pins_type exp_fail(input tpf_pkg::tpf_pins_type drv,
		input tpf_pkg::tpf_pins_type inv, input tpf_pkg::tpf_pins_type f,
		input tpf_pkg::tpf_pins_type care, input logic auto_ign);
		return ((drv & inv) ^ f) & care & (auto_ign ? ~drv : {60{1'b1}});
	endfunction

	initial begin
		#(20ns * 20000);
		failures++;
		end_of_test();
	end

	initial begin
		logic [31:0]           r;
		logic [31:0]           r2;
		tpf_pkg::tpf_pins_type a;
		tpf_pkg::tpf_pins_type b;
		tpf_pkg::tpf_pins_type m1;
		tpf_pkg::tpf_pins_type m2;
		tpf_pkg::tpf_pins_type inv;
		tpf_pkg::tpf_pins_type d;
		tpf_pkg::tpf_pins_type f;
		tpf_pkg::tpf_pins_type sel_d;
		tpf_pkg::tpf_pins_type prev;
		i_rst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		resp = '0;
		fault = '0;
		failures = 0;
		tests_run = 0;
		r = $urandom(26);
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		check(o_fast_switch, 60'h0);
		check(o_driver_relay, 60'h0);
		rd(`TPF_OFF_PERIOD, r);
		check(r, 32'h20);
		rd(`TPF_OFF_EARLY, r);
		check(r, 32'h0408);
		rd(`TPF_OFF_LATE, r);
		check(r, 32'h0410);
		rd(8'h7C, r);
		check(r, 32'h0);
		a = rnd60() & ~60'h1;
		b = rnd60();
		m1 = rnd60() | 60'h1;
		m2 = rnd60() | 60'h1;
		inv = rnd60();
		wr60(`TPF_OFF_DRV1, a);
		wr60(`TPF_OFF_DRV2, b);
		wr60(`TPF_OFF_CMP1, m1);
		wr60(`TPF_OFF_CMP2, m2);
		wr60(`TPF_OFF_INVERT, inv);
		wr(`TPF_OFF_IRQ_MASK, 32'h1);
		prev = '0;
		// Both drive/compare sets, selected together, each with and without auto ignore
		for (int k = 0; k < 4; k++) begin
			d = rnd60();
			f = rnd60() | 60'h1;
			wr(`TPF_OFF_CTRL, 32'h0);
			wr(`TPF_OFF_LOAD_PTR, 32'h0);
			wr(`TPF_OFF_RESULT, 32'h0);
			wr(`TPF_OFF_PAT_LO, d[31:0]);
			wr(`TPF_OFF_PAT_HI, {2'b00, k[0], k[0], d[59:32]});
			rd(`TPF_OFF_LOAD_PTR, r);
			check(r, 32'h1);
			@(posedge i_clk);
			resp <= d;
			fault <= f;
			@(negedge i_clk);
			check(o_fast_switch, prev);
			wr(`TPF_OFF_CTRL, {30'h0, k[1], 1'b1});
			wait_start();
			sel_d = k[0] ? b : a;
			check(o_fast_switch, sel_d);
			check(o_driver_relay, a | b);
			@(negedge i_clk);
			check(o_pin_drive, d ^ inv);
			repeat (40) @(negedge i_clk);
			wr(`TPF_OFF_CTRL, 32'h0);
			rd(`TPF_OFF_RESULT, r);
			rd(`TPF_OFF_RESULT + 8'h04, r2);
			check({r2[27:0], r}, exp_fail(sel_d, inv, f, k[0] ? m2 : m1, k[1]));
			prev = sel_d;
		end
		check(o_irq, 1'b1);
		rd(`TPF_OFF_STATUS, r);
		check(r[0], 1'b1);
		repeat (2) @(negedge i_clk);
		check(o_irq, 1'b0);
		// Early window closed, so select-0 pins can only fail through the dual late strobe
		wr(`TPF_OFF_EARLY, 32'h0008);
		a = rnd60();
		wr60(`TPF_OFF_STB_SEL, a);
		for (int g = 0; g < 2; g++) begin
			wr(`TPF_OFF_RESULT, 32'h0);
			wr(`TPF_OFF_CTRL, {29'h0, g[0], 2'b01});
			wait_start();
			repeat (40) @(negedge i_clk);
			wr(`TPF_OFF_CTRL, 32'h0);
			rd(`TPF_OFF_RESULT, r);
			rd(`TPF_OFF_RESULT + 8'h04, r2);
			check({r2[27:0], r}, exp_fail(b, inv, f, m2 & (a | {60{g[0]}}), 1'b0));
		end
		// Return-low drive: rest level outside the pulse, data inside it
		wr60(`TPF_OFF_RET_LOW, {60{1'b1}});
		for (int h = 0; h < 2; h++) begin
			wr(`TPF_OFF_CTRL, 32'h0);
			wr(`TPF_OFF_CTRL, {28'h0, h[0], 3'b001});
			wait_start();
			repeat (2) @(negedge i_clk);
			check(o_pin_drive, inv & {60{h[0]}});
			repeat (6) @(negedge i_clk);
			check(o_pin_drive, (d ^ inv) ^ (inv & {60{h[0]}}));
		end
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
